//--- verilog/drvcs_pkg.sv
package drvcs_pkg;

  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS      = 25;
  localparam int unsigned OL_FILTER_TIME_US  = 1000;
  localparam int unsigned OL_FILTER_CYC      = (OL_FILTER_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_TIME_US    = 100;
  localparam int unsigned STARTUP_CYC        = (STARTUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_TICK_TIME_NS   = 1000;
  localparam int unsigned REC_TICK_CYC       = REC_TICK_TIME_NS / CLK_PERIOD_NS;

  // Recovery off-time in recovery ticks, per duty selection
  localparam logic [7:0]  REC_OFF_TICKS_LO   = 8'h10;
  localparam logic [7:0]  REC_OFF_TICKS_HI   = 8'h40;

  // Driver stage count and order: first_output_stage ls/hs, second_output_stage ls/hs, third_output_stage ls/hs, fourth_output_stage hs, fifth_output_stage hs
  localparam int unsigned NUM_STAGES         = 8;
  localparam int unsigned NUM_OUTPUTS        = 5;

  // Configuration word one fields
  localparam int unsigned CFG_DUTY_BIT       = 13;
  localparam int unsigned CFG_REC_LSB        = 6;
  localparam int unsigned CFG_PWM_LSB        = 1;
  localparam logic [15:0] CFG_RESET          = 16'h0000;

  // Diagnostic word one and word zero fields
  localparam int unsigned DIAG_MARK_BIT      = 15;
  localparam int unsigned DIAG_OV_BIT        = 14;
  localparam int unsigned DIAG_UV_BIT        = 13;
  localparam int unsigned DIAG_TSD_BIT       = 12;
  localparam int unsigned DIAG_TW_BIT        = 11;
  localparam int unsigned DIAG_NRDY_BIT      = 10;
  localparam int unsigned DIAG_ZERO_BIT      = 9;
  localparam int unsigned DIAG_OL_LSB        = 1;
  localparam int unsigned DIAG_OC_LSB        = 1;
  localparam int unsigned DIAG_NOERR_BIT     = 0;
  localparam logic [15:0] DIAG1_RESET        = 16'h8000;
  localparam logic [15:0] DIAG0_RESET        = 16'h0000;

  // Output index for each driver stage
  localparam logic [2:0]  STAGE_OUT [NUM_STAGES] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4};

endpackage

//--- verilog/drvcs_reg1.sv
`timescale 1ns/100ps
// Function
// - Diagnostic word 1 bit 15 always reads one so all-zero or all-one frames expose a broken link.
// - Supply overvoltage sets bit 14, undervoltage sets bit 13, and either turns all outputs off.
// - Thermal shutdown turns every output off and shows in diagnostic bit 12.
// - The host clears the thermal shutdown flag with the reset bit; outputs stay off until then and return after.
// - Temperature warning shows in bit 11 for information and never changes the outputs.
// - An overcurrent in a stage sets its flag in diagnostic word 0 and turns that stage off.
// - Configuration bits 10 down to 6 let outputs five to one switch back on by themselves after a delay.
// - Repeated trip and recovery gives a pulsed current whose duty is chosen by configuration bit 13.
// - With the enable clear no recovery happens at any internal clock phase; only the reset bit switches the stage back on.
// - Leaving standby starts a start-up timer, sets not-ready bit 10 and keeps outputs off meanwhile.
// - The not-ready bit clears itself when the start-up timer runs out, in step with the internal clock.
// - Diagnostic bit 9 reads zero while configuration bit 9 enables recovery for the fourth output.
// - Load current is watched in every active stage and open-load shows in diagnostic bits 8 to 1.
// - An open-load flag sets only after low current lasts at least 1 ms while the stage is on.
// - With PWM-follow set and the output on, the output follows the PWM input.
// - Bit 0 of each diagnostic word is the NOR of bits 1 to 14 of both words, open-load masked by its disable.
module drvcs_reg1
  import drvcs_pkg::*;
#(
  parameter int unsigned OL_FILTER_CYCLES = OL_FILTER_CYC,
  parameter int unsigned STARTUP_CYCLES   = STARTUP_CYC
)(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // Register port
  input  wire logic                  cfg_wr_i,
  input  wire logic [15:0]           cfg_wdata_i,
  input  wire logic                  flag_clear_i,
  input  wire logic                  ol_disable_i,
  input  wire logic [NUM_STAGES-1:0] stage_on_i,
  output logic      [15:0]           diag_word1_o,
  output logic      [15:0]           diag_word0_o,
  // Analogue monitors
  input  wire logic                  active_mode_i,
  input  wire logic                  supply_rail_ov_i,
  input  wire logic                  supply_rail_uv_i,
  input  wire logic                  thermal_shutdown_i,
  input  wire logic                  thermal_warning_i,
  input  wire logic [NUM_STAGES-1:0] overcurrent_i,
  input  wire logic [NUM_STAGES-1:0] load_current_low_i,
  // Drive
  input  wire logic                  pwm_i,
  output logic      [NUM_STAGES-1:0] stage_drive_o
);

  // State
  logic [15:0]           cfg_q;
  logic                  ov_q;
  logic                  uv_q;
  logic                  thermal_shutdown_flag_q;
  logic                  tw_q;
  logic                  not_ready_q;
  logic                  active_q;
  // Wide counters so the real filter time fits without change
  logic [31:0]           start_cnt_q;
  logic [31:0]           tick_cnt_q;
  logic                  tick_q;
  logic [NUM_STAGES-1:0] oc_q;
  logic [NUM_STAGES-1:0] ol_q;
  logic [NUM_STAGES-1:0] drive_q;
  logic [15:0]           diag1_q;
  logic [15:0]           diag0_q;

  // Decode
  wire logic                   leave_standby;
  wire logic                   global_off;
  wire logic [NUM_STAGES-1:0]  drive_d;
  wire logic [NUM_STAGES-1:0]  rec_done;
  wire logic [15:0]            diag1_d;
  wire logic [15:0]            diag0_d;
  wire logic [NUM_STAGES-1:0]  ol_seen;
  wire logic                   no_error;
  wire logic                   supply_err;
  wire logic                   thermal_err;
  wire logic                   open_load_err;
  wire logic                   startup_off;
  wire logic                   tick_wrap;
  wire logic                   start_done;
  wire logic                   cfg_duty;
  wire logic [NUM_OUTPUTS-1:0] cfg_rec_en;
  wire logic [NUM_OUTPUTS-1:0] cfg_pwm_en;

  assign leave_standby = active_mode_i & ~active_q;
  assign supply_err    = ov_q | uv_q;
  assign startup_off   = not_ready_q | ~active_q;
  // All-stage shutdown sources; warning deliberately absent
  assign global_off    = supply_err | thermal_shutdown_flag_q | startup_off;

  // Configuration word, write only
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      cfg_q <= CFG_RESET;
    else if (cfg_wr_i)
      cfg_q <= cfg_wdata_i;
  end

  assign cfg_duty   = cfg_q[CFG_DUTY_BIT];
  assign cfg_rec_en = cfg_q[CFG_REC_LSB +: NUM_OUTPUTS];
  assign cfg_pwm_en = cfg_q[CFG_PWM_LSB +: NUM_OUTPUTS];

  // Supply monitors follow their pins; not latched
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ov_q <= 1'b0;
    else
      ov_q <= supply_rail_ov_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      uv_q <= 1'b0;
    else
      uv_q <= supply_rail_uv_i;
  end

  // Warning is information only, never gates a stage
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tw_q <= 1'b0;
    else
      tw_q <= thermal_warning_i;
  end

  // Sticky shutdown; set wins over a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      thermal_shutdown_flag_q <= 1'b0;
    else if (thermal_shutdown_i)
      thermal_shutdown_flag_q <= 1'b1;
    else if (flag_clear_i)
      thermal_shutdown_flag_q <= 1'b0;
  end

  // Standby tracker; its rising edge starts the timer
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      active_q <= 1'b0;
    else
      active_q <= active_mode_i;
  end

  // Start-up timer after leaving standby
  assign start_done = start_cnt_q >= STARTUP_CYCLES - 1;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      not_ready_q <= 1'b0;
      start_cnt_q <= 32'h0;
    end
    else if (leave_standby)
    begin
      not_ready_q <= 1'b1;
      start_cnt_q <= 32'h0;
    end
    else if (not_ready_q)
    begin
      start_cnt_q <= start_cnt_q + 32'h1;
      if (start_done)
        not_ready_q <= 1'b0;
    end
  end

  // Shared recovery tick; a trip lands at any phase of it
  assign tick_wrap = tick_cnt_q == REC_TICK_CYC - 1;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tick_cnt_q <= 32'h0;
    else if (tick_wrap)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h1;
  end

  // Registered pulse keeps the compare off the recovery path
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tick_q <= 1'b0;
    else
      tick_q <= tick_wrap;
  end

  // Per-stage overcurrent recovery and open-load filter
  for (genvar s = 0; s < NUM_STAGES; s++)
  begin : g_stage
    logic [7:0]      rec_cnt_q;
    logic [31:0]     ol_cnt_q;
    wire logic       rec_en;
    wire logic [7:0] rec_limit;
    wire logic       oc_trip;
    wire logic       low_driven;
    wire logic       pwm_gate;

    assign rec_en      = cfg_rec_en[STAGE_OUT[s]];
    // Duty bit picks the off time; on time is set by the load tripping again
    assign rec_limit   = cfg_duty ? REC_OFF_TICKS_HI : REC_OFF_TICKS_LO;
    assign rec_done[s] = oc_q[s] & rec_en & tick_q & (rec_cnt_q >= rec_limit);
    assign ol_seen[s]  = ol_cnt_q >= OL_FILTER_CYCLES - 1;
    assign oc_trip     = overcurrent_i[s] & drive_q[s];
    assign low_driven  = drive_q[s] & load_current_low_i[s];

    // Trips only count on a driven stage; set wins over clear
    always_ff @(posedge clk_i)
    begin
      if (sys_rst_i)
        oc_q[s] <= 1'b0;
      else if (oc_trip)
        oc_q[s] <= 1'b1;
      else if (flag_clear_i | rec_done[s])
        oc_q[s] <= 1'b0;
    end

    // Off-time in ticks; saturates rather than wrapping
    always_ff @(posedge clk_i)
    begin
      if (sys_rst_i)
        rec_cnt_q <= 8'h00;
      else if (!oc_q[s])
        rec_cnt_q <= 8'h00;
      else if (tick_q & rec_cnt_q != 8'hFF)
        rec_cnt_q <= rec_cnt_q + 8'h01;
    end

    // Low current must persist while driven; any gap restarts the filter
    always_ff @(posedge clk_i)
    begin
      if (sys_rst_i)
        ol_cnt_q <= 32'h0;
      else if (!low_driven)
        ol_cnt_q <= 32'h0;
      else if (!ol_seen[s])
        ol_cnt_q <= ol_cnt_q + 32'h1;
    end

    always_ff @(posedge clk_i)
    begin
      if (sys_rst_i)
        ol_q[s] <= 1'b0;
      else if (low_driven & ol_seen[s])
        ol_q[s] <= 1'b1;
      else if (flag_clear_i)
        ol_q[s] <= 1'b0;
    end

    // PWM follow for the stage's output
    assign pwm_gate   = ~cfg_pwm_en[STAGE_OUT[s]] | pwm_i;
    assign drive_d[s] = stage_on_i[s] & ~oc_q[s] & ~global_off & pwm_gate;
  end

  // Diagnostic words
  assign thermal_err   = thermal_shutdown_flag_q | tw_q;
  // Disable masks only the summary, the flags still report
  assign open_load_err = (|ol_q) & ~ol_disable_i;
  assign no_error      = ~(supply_err | thermal_err | not_ready_q | (|oc_q) | open_load_err);

  // Marker and spare bits are constants so a dead link shows
  assign diag1_d = {1'b1, ov_q, uv_q, thermal_shutdown_flag_q, tw_q, not_ready_q, 1'b0,
                    ol_q, no_error};
  assign diag0_d = {7'h00, oc_q, no_error};

  // Registered so every output leaves a flip-flop
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      drive_q <= '0;
    else
      drive_q <= drive_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      diag1_q <= DIAG1_RESET;
    else
      diag1_q <= diag1_d;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      diag0_q <= DIAG0_RESET;
    else
      diag0_q <= diag0_d;
  end

  assign stage_drive_o = drive_q;
  assign diag_word1_o  = diag1_q;
  assign diag_word0_o  = diag0_q;

endmodule // drvcs_reg1

//--- sim/drvcs_props_properties.sv
`timescale 1ns/100ps
module drvcs_props
  import drvcs_pkg::*;
(
  // Watched ports
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  flag_clear_i,
  input wire logic                  ol_disable_i,
  input wire logic                  supply_rail_ov_i,
  input wire logic                  supply_rail_uv_i,
  input wire logic                  thermal_shutdown_i,
  input wire logic [NUM_STAGES-1:0] overcurrent_i,
  input wire logic [15:0]           diag_word1_o,
  input wire logic [15:0]           diag_word0_o,
  input wire logic [NUM_STAGES-1:0] stage_drive_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_mark_bit_one: assert property (diag_word1_o[15])
    else $error("Marker bit low");
  a_spare_bit_zero: assert property (!diag_word1_o[9])
    else $error("Spare bit high");
  a_supply_drive_off: assert property (supply_rail_ov_i || supply_rail_uv_i |-> ##2 stage_drive_o == '0)
    else $error("Drive on with bad supply");
  a_shutdown_all_off: assert property (thermal_shutdown_i |-> ##2 diag_word1_o[12] && stage_drive_o == '0)
    else $error("Shutdown not taken");
  a_shutdown_host_clear: assert property ($fell(diag_word1_o[12]) |-> $past(flag_clear_i, 2))
    else $error("Shutdown flag dropped alone");
  a_overcurrent_trip: assert property (overcurrent_i[0] && stage_drive_o[0] |-> ##2 diag_word0_o[1] && !stage_drive_o[0])
    else $error("Overcurrent not taken");
  a_not_ready_off: assert property (diag_word1_o[10] |-> stage_drive_o == '0)
    else $error("Drive on while not ready");
  // Two cycles after reset so the reset image is not judged; disable seen one cycle late
  a_no_error_nor: assert property (!$past(sys_rst_i) && !$past(sys_rst_i, 2) |->
    diag_word1_o[0] == diag_word0_o[0] && diag_word1_o[0] == !(|diag_word1_o[14:9] || |diag_word0_o[14:1]
    || (|diag_word1_o[8:1] && !$past(ol_disable_i))))
    else $error("No-error bit wrong");
endmodule // drvcs_props
bind drvcs_reg1 drvcs_props props_u (.*);

//--- sim/drvcs_host.sv
`timescale 1ns/100ps
module drvcs_host (
  // Clock
  input  wire logic        clk_i,
  // Register port drive
  output logic             cfg_wr_o,
  output logic      [15:0] cfg_wdata_o,
  output logic             flag_clear_o
);
  initial
  begin
    cfg_wr_o = 1'b0;
    cfg_wdata_o = 16'hFFFF;
    flag_clear_o = 1'b0;
  end
  // Data inverted after the strobe so a stale word never looks valid
  task automatic write_cfg(input logic [15:0] v);
    @(posedge clk_i);
    cfg_wr_o <= 1'b1;
    cfg_wdata_o <= v;
    @(posedge clk_i);
    cfg_wr_o <= 1'b0;
    cfg_wdata_o <= ~v;
  endtask
  task automatic clear_flags();
    @(posedge clk_i);
    flag_clear_o <= 1'b1;
    @(posedge clk_i);
    flag_clear_o <= 1'b0;
  endtask
endmodule // drvcs_host

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import drvcs_pkg::*;
  localparam int OLC = 20;
  localparam int SUC = 10;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, ol_disable_i = 1'b0, pwm_i = 1'b0, active_mode_i = 1'b0;
  logic supply_rail_ov_i = 1'b0, supply_rail_uv_i = 1'b0, thermal_shutdown_i = 1'b0, thermal_warning_i = 1'b0;
  logic [7:0]  stage_on_i = '0, overcurrent_i = '0, load_current_low_i = '0, stage_drive_o;
  logic [15:0] cfg_wdata_i, diag_word1_o, diag_word0_o;
  logic        cfg_wr_i, flag_clear_i;
  wire  [15:0] d1 = diag_word1_o;
  wire  [7:0]  drv = stage_drive_o;
  int          fails = 0, num_checks = 0, cyc = 0, n, m;
  drvcs_reg1 #(.OL_FILTER_CYCLES(OLC), .STARTUP_CYCLES(SUC)) dut_u (.*);
  drvcs_host host_u (.clk_i(clk_i), .cfg_wr_o(cfg_wr_i), .cfg_wdata_o(cfg_wdata_i), .flag_clear_o(flag_clear_i));
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Sample after the edge so its updates have landed
  task automatic see(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    see(19);
    chk(d1, DIAG1_RESET);
    chk(diag_word0_o, DIAG0_RESET);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    active_mode_i <= 1'b1;
    stage_on_i <= 8'h01;
    see(3);
    chk(d1[10], 1'b1);
    chk(drv, 8'h00);
    see(SUC + 4);
    chk(d1[10], 1'b0);
    chk(drv, 8'h01);
    chk({d1[0], diag_word0_o[0]}, 2'h3);
    host_u.write_cfg(16'h0002);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk_i);
      pwm_i <= p[0];
      see(3);
      chk(drv, {7'h00, p[0]});
    end
    $display("Startup and follow tests done");
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk_i);
      {supply_rail_ov_i, supply_rail_uv_i, thermal_shutdown_i} <= 3'h4 >> k;
      see(3);
      chk(d1[14:12], 3'h4 >> k);
      chk(drv, 8'h00);
      @(posedge clk_i);
      {supply_rail_ov_i, supply_rail_uv_i, thermal_shutdown_i} <= 3'h0;
      see(4);
      chk(drv, (k == 2) ? 8'h00 : 8'h01);
    end
    host_u.clear_flags();
    see(4);
    chk({d1[12], drv}, 9'h001);
    @(posedge clk_i);
    thermal_warning_i <= 1'b1;
    see(3);
    chk({d1[11], drv}, 9'h101);
    chk({d1[0], diag_word0_o[0]}, 2'h0);
    @(posedge clk_i);
    thermal_warning_i <= 1'b0;
    $display("Supply and thermal tests done");
    // Trip on both stages, only the driven one latches; host clear restores it
    @(posedge clk_i);
    overcurrent_i <= 8'h03;
    @(posedge clk_i);
    overcurrent_i <= 8'h00;
    see(3);
    chk(diag_word0_o, 16'h0002);
    chk(drv, 8'h00);
    host_u.clear_flags();
    see(3);
    chk({diag_word0_o[1], drv}, 9'h001);
    $display("Overcurrent clear test done");
    // Off-time is timed only to within two ticks, the counting phase drifts
    for (int k = 0; k < 2; k++)
    begin
      host_u.write_cfg({2'h0, k[0], 13'h0040});
      @(posedge clk_i);
      overcurrent_i <= 8'h01;
      @(posedge clk_i);
      overcurrent_i <= 8'h00;
      see(3);
      chk({diag_word0_o[1], drv}, 9'h100);
      n = 0;
      while (drv !== 8'h01 && n < 3000)
      begin
        see(1);
        n++;
      end
      m = (k ? REC_OFF_TICKS_HI : REC_OFF_TICKS_LO) * REC_TICK_CYC;
      chk(n > m - 80 && n < m + 80, 1'b1);
    end
    $display("Recovery tests done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk_i);
      load_current_low_i <= 8'h01;
      repeat (OLC - 3 + 8 * k) @(posedge clk_i);
      load_current_low_i <= 8'h00;
      see(3);
      chk(d1[1], k[0]);
    end
    chk({d1[0], diag_word0_o[0]}, 2'h0);
    @(posedge clk_i);
    ol_disable_i <= 1'b1;
    see(3);
    chk({d1[1], d1[0], diag_word0_o[0]}, 3'h7);
    $display("Open-load test done");
    finish_test();
  end
endmodule // testbench
